// [rtl/sitim_core.sv]
// integration timing engine with Avalon-MM register slave
//
// Behaviour
// - step lasts (step size + 1) ticks
// - step size resets to 999
// - step size low byte then high byte
// - wait enable defers next measurement start
// - wait is (n + 1) times 2.78 ms (here 2.75 ms: the tick is 55 clocks of 50 ns)
// - too short wait sets trigger error flag
// - pulse mode reports length in ticks
// - length is 24-bit read-only, resets zero
// - pulse mode integrates until edge count reached
// - edges counted equal setting plus one
// - gain code 0..10 doubles from 0.5x
// - gain drives all six ADC channels
// - timed integration is (count+1)(size+1) ticks
// - full scale is (count+1)(size+1)
//
// Chosen here: the Avalon-MM register port.
module sitim_core
  import sitim_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int WAIT_TICK_COUNT = WAIT_TICKS
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [sitim_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SYNC_IN,
  output logic INTEGRATING,
  output logic MEAS_DONE,
  output logic [31:0] ADC_FULL_SCALE,
  output logic [10:0] ADC_GAIN_FACTOR_X2 [sitim_pkg::NUM_ADC]
);
  import sitim_pkg::*;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] step_size_reg;
  logic [7:0] step_count_reg;
  logic [7:0] wait_period_reg;
  logic [7:0] sync_target_reg;
  logic [7:0] enable_reg;
  logic [7:0] gain_config_reg;
  logic [7:0] mode_reg;
  logic trig_err_reg;
  logic [23:0] meas_len_reg;
  logic ack_reg;

  logic [7:0] reg_index;
  logic wr_go;
  logic rd_go;
  logic trig_err_set;
  sitim_mode_e mode;

  assign reg_index = AVS_ADDRESS[ADDR_W-1:2];
  assign wr_go = AVS_WRITE && !ack_reg && AVS_BYTEENABLE[0];
  assign rd_go = AVS_READ && !ack_reg;
  assign mode = sitim_mode_e'(mode_reg[MODE_LSB +: 2]);

  // one cycle of wait state: request taken, answered on the next edge
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ || AVS_WRITE) && !ack_reg;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_reg);
    end
  end

  // step size reset and byte split
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      step_size_reg <= STEP_SIZE_RESET;
      step_count_reg <= BYTE_ZERO;
      wait_period_reg <= BYTE_ZERO;
      sync_target_reg <= BYTE_ZERO;
      enable_reg <= BYTE_ZERO;
      gain_config_reg <= GAIN_CONFIG_RESET;
      mode_reg <= BYTE_ZERO;
    end else if (wr_go) begin
      unique case (reg_index)
        OFS_STEP_LOW: step_size_reg[7:0] <= AVS_WRITEDATA[7:0];
        OFS_STEP_HIGH: step_size_reg[15:8] <= AVS_WRITEDATA[7:0];
        OFS_STEP_COUNT: step_count_reg <= AVS_WRITEDATA[7:0];
        OFS_WAIT_PERIOD: wait_period_reg <= AVS_WRITEDATA[7:0];
        OFS_SYNC_TARGET: sync_target_reg <= AVS_WRITEDATA[7:0];
        OFS_ENABLE: enable_reg <= AVS_WRITEDATA[7:0];
        OFS_GAIN_CONFIG: gain_config_reg <= {3'h0, AVS_WRITEDATA[4:0]};
        OFS_MODE: mode_reg <= AVS_WRITEDATA[7:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped offsets read as zero
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (rd_go) begin
      unique case (reg_index)
        OFS_LEN_LOW: AVS_READDATA <= {24'h00_0000, meas_len_reg[7:0]};
        OFS_LEN_MID: AVS_READDATA <= {24'h00_0000, meas_len_reg[15:8]};
        OFS_LEN_HIGH: AVS_READDATA <= {24'h00_0000, meas_len_reg[23:16]};
        OFS_STEP_LOW: AVS_READDATA <= {24'h00_0000, step_size_reg[7:0]};
        OFS_STEP_HIGH: AVS_READDATA <= {24'h00_0000, step_size_reg[15:8]};
        OFS_STEP_COUNT: AVS_READDATA <= {24'h00_0000, step_count_reg};
        OFS_WAIT_PERIOD: AVS_READDATA <= {24'h00_0000, wait_period_reg};
        OFS_SYNC_TARGET: AVS_READDATA <= {24'h00_0000, sync_target_reg};
        OFS_ENABLE: AVS_READDATA <= {24'h00_0000, enable_reg};
        OFS_GAIN_CONFIG: AVS_READDATA <= {24'h00_0000, gain_config_reg};
        OFS_MODE: AVS_READDATA <= {24'h00_0000, mode_reg};
        OFS_STATUS: AVS_READDATA <= 32'(trig_err_reg) << ST_TRIG_ERR_BIT;
        default: AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // common tick
  // ------------------------------------------------------------
  logic [15:0] tick_cnt_reg;
  logic tick;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tick_cnt_reg <= 16'h0000;
    end else if (tick_cnt_reg == 16'(TICK_CYC - 1)) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end
  assign tick = (tick_cnt_reg == 16'(TICK_CYC - 1));

  // ------------------------------------------------------------
  // sync pin
  // ------------------------------------------------------------
  logic sync_s1_reg;
  logic sync_s2_reg;
  logic sync_d_reg;
  logic sync_fall;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync_s1_reg <= 1'b1;
      sync_s2_reg <= 1'b1;
      sync_d_reg <= 1'b1;
    end else begin
      sync_s1_reg <= SYNC_IN;
      sync_s2_reg <= sync_s1_reg;
      sync_d_reg <= sync_s2_reg;
    end
  end
  assign sync_fall = sync_d_reg && !sync_s2_reg;

  // ------------------------------------------------------------
  // measurement sequencer
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SITIM_IDLE,
    SITIM_ARM,
    SITIM_INTEG
  } sitim_state_e;

  sitim_state_e state_reg;
  logic [15:0] step_tick_reg;
  logic [8:0] step_num_reg;
  logic [8:0] edge_num_reg;
  logic [23:0] len_cnt_reg;
  logic [9:0] wait_tick_reg;
  logic [8:0] wait_cyc_reg;
  logic wait_run_reg;
  logic meas_en;
  logic wait_en;
  logic start_ok;
  logic step_end;
  logic integ_end;
  logic wait_expire;

  assign meas_en = enable_reg[EN_MEAS_BIT];
  assign wait_en = enable_reg[EN_WAIT_BIT];
  // step boundary every step size + 1 ticks
  assign step_end = tick && (step_tick_reg == step_size_reg);
  // wait period of n + 1 wait cycles
  assign wait_expire = wait_run_reg && tick
    && (wait_tick_reg == 10'(WAIT_TICK_COUNT - 1)) && (wait_cyc_reg == {1'b0, wait_period_reg});
  // pulse mode ends on edge setting + 1 falling edges
  assign integ_end = (state_reg == SITIM_INTEG) && ((mode == SITIM_MODE_PULSE)
    ? (sync_fall && (edge_num_reg == {1'b0, sync_target_reg}))
    : (step_end && (step_num_reg == {1'b0, step_count_reg})));
  // with wait enabled, the first start is immediate, later starts only on wait expiry
  assign start_ok = !wait_en || !wait_run_reg || wait_expire;

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= SITIM_IDLE;
    end else if (!meas_en) begin
      state_reg <= SITIM_IDLE;
    end else begin
      unique case (state_reg)
        SITIM_IDLE: if (start_ok) state_reg <= SITIM_ARM;
        SITIM_ARM: begin
          if (mode == SITIM_MODE_SW) begin
            state_reg <= SITIM_INTEG;
          end else if (sync_fall) begin
            state_reg <= SITIM_INTEG;
          end
        end
        SITIM_INTEG: if (integ_end) state_reg <= SITIM_IDLE;
        default: state_reg <= SITIM_IDLE;
      endcase
    end
  end

  // timed integration counts steps of size + 1 ticks
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      step_tick_reg <= 16'h0000;
      step_num_reg <= 9'h000;
    end else if (state_reg != SITIM_INTEG) begin
      step_tick_reg <= 16'h0000;
      step_num_reg <= 9'h000;
    end else if (step_end) begin
      step_tick_reg <= 16'h0000;
      step_num_reg <= step_num_reg + 9'h001;
    end else if (tick) begin
      step_tick_reg <= step_tick_reg + 16'h0001;
    end
  end

  // edge counter and length counter for pulse mode
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      edge_num_reg <= 9'h000;
      len_cnt_reg <= 24'h00_0000;
    end else if (state_reg != SITIM_INTEG) begin
      edge_num_reg <= 9'h000;
      len_cnt_reg <= 24'h00_0000;
    end else begin
      if (sync_fall) edge_num_reg <= edge_num_reg + 9'h001;
      if (tick && len_cnt_reg != 24'hFF_FFFF) len_cnt_reg <= len_cnt_reg + 24'h00_0001;
    end
  end

  // capture length when a pulse integration ends
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      meas_len_reg <= 24'h00_0000;
    end else if (integ_end && mode == SITIM_MODE_PULSE) begin
      meas_len_reg <= len_cnt_reg;
    end
  end

  // wait timer restarts at each measurement start
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wait_run_reg <= 1'b0;
      wait_tick_reg <= 10'h000;
      wait_cyc_reg <= 9'h000;
    end else if (!meas_en || !wait_en) begin
      wait_run_reg <= 1'b0;
      wait_tick_reg <= 10'h000;
      wait_cyc_reg <= 9'h000;
    end else if (state_reg == SITIM_IDLE && start_ok) begin
      wait_run_reg <= 1'b1;
      wait_tick_reg <= 10'h000;
      wait_cyc_reg <= 9'h000;
    end else if (wait_run_reg && tick) begin
      if (wait_tick_reg == 10'(WAIT_TICK_COUNT - 1)) begin
        wait_tick_reg <= 10'h000;
        if (!wait_expire) wait_cyc_reg <= wait_cyc_reg + 9'h001;
      end else begin
        wait_tick_reg <= wait_tick_reg + 10'h001;
      end
    end
  end

  // wait expired while measurement still busy; set wins over clear
  assign trig_err_set = wait_expire && (state_reg != SITIM_IDLE);
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      trig_err_reg <= 1'b0;
    end else if (trig_err_set) begin
      trig_err_reg <= 1'b1;
    end else if (wr_go && reg_index == OFS_STATUS && AVS_WRITEDATA[ST_TRIG_ERR_BIT]) begin
      trig_err_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      INTEGRATING <= 1'b0;
      MEAS_DONE <= 1'b0;
      ADC_FULL_SCALE <= 32'h0000_0000;
    end else begin
      INTEGRATING <= (state_reg == SITIM_INTEG) && !integ_end;
      MEAS_DONE <= integ_end;
      ADC_FULL_SCALE <= (32'(step_count_reg) + 32'h1) * (32'(step_size_reg) + 32'h1);
    end
  end

  // gain code decode in half-units; codes above 10 clamp
  // doubled 512x is 1024, so the factor needs eleven bits
  function automatic logic [10:0] gain_x2(input logic [4:0] code);
    logic [4:0] c;
    c = (code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : code;
    gain_x2 = 11'h001 << c;
  endfunction

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < NUM_ADC; i++) ADC_GAIN_FACTOR_X2[i] <= 11'h000;
    end else begin
      for (int i = 0; i < NUM_ADC; i++) ADC_GAIN_FACTOR_X2[i] <= gain_x2(gain_config_reg[4:0]);
    end
  end
endmodule

// [rtl/sitim_pkg.sv]
// package: register map, field layout, reset values and timing for the integration timing block
package sitim_pkg;
  // byte offsets of the 8-bit registers (index); the bus byte address is four times the index
  localparam logic [7:0] OFS_LEN_LOW = 8'h63;
  localparam logic [7:0] OFS_LEN_MID = 8'h64;
  localparam logic [7:0] OFS_LEN_HIGH = 8'h65;
  localparam logic [7:0] OFS_SYNC_TARGET = 8'h72;
  localparam logic [7:0] OFS_ENABLE = 8'h80;
  localparam logic [7:0] OFS_STEP_COUNT = 8'h81;
  localparam logic [7:0] OFS_WAIT_PERIOD = 8'h83;
  localparam logic [7:0] OFS_STATUS = 8'hA7;
  localparam logic [7:0] OFS_GAIN_CONFIG = 8'hAA;
  localparam logic [7:0] OFS_STEP_LOW = 8'hCA;
  localparam logic [7:0] OFS_STEP_HIGH = 8'hCB;
  localparam logic [7:0] OFS_MODE = 8'hD0;
  localparam int ADDR_W = 10;

  // enable register fields
  localparam int EN_MEAS_BIT = 1;
  localparam int EN_WAIT_BIT = 3;
  // status register field
  localparam int ST_TRIG_ERR_BIT = 4;
  // mode register fields
  localparam int MODE_LSB = 0;
  localparam int MODE_START_BIT = 2;

  localparam logic [15:0] STEP_SIZE_RESET = 16'h03E7;
  localparam logic [7:0] GAIN_CONFIG_RESET = 8'h09;
  localparam logic [4:0] GAIN_CODE_MAX = 5'h0A;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int NUM_ADC = 6;

  // tick period in picoseconds and system clock period in picoseconds
  localparam int TICK_PS = 2780000;
  localparam int CLK_PS = 50000;
  localparam int TICK_CYCLES = TICK_PS / CLK_PS;
  // one wait cycle is 1000 ticks of 55 clocks, i.e. 2.75 ms
  localparam int WAIT_TICKS = 1000;

  typedef enum logic [1:0] {
    SITIM_MODE_SW,
    SITIM_MODE_EXT_START,
    SITIM_MODE_RSVD,
    SITIM_MODE_PULSE
  } sitim_mode_e;
endpackage

// [verif/sitim_core_properties.sv]
// checker: bus handshake, gain and measurement output properties
module sitim_props
  import sitim_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic INTEGRATING,
  input wire logic MEAS_DONE,
  input wire logic [31:0] ADC_FULL_SCALE,
  input wire logic [10:0] ADC_GAIN_FACTOR_X2 [sitim_pkg::NUM_ADC]
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  chk_ack_next_cycle: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("ack late");
  chk_ack_one_wide: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("ack too long");
  chk_no_idle_ack: assert property (
    !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST) else $error("ack without request");
  chk_read_upper_zero: assert property (
    !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0) else $error("upper read bits set");
  chk_reset_defaults: assert property (
    $rose(RESETN) |=> ADC_FULL_SCALE == 32'd1000 && ADC_GAIN_FACTOR_X2[0] == 11'h200)
    else $error("bad defaults after reset");
  chk_gain_power_two: assert property (
    $past(RESETN) |-> $onehot(ADC_GAIN_FACTOR_X2[0])) else $error("gain not a power of two");
  chk_six_gains_equal: assert property (
    ADC_GAIN_FACTOR_X2[1] == ADC_GAIN_FACTOR_X2[0] && ADC_GAIN_FACTOR_X2[2] == ADC_GAIN_FACTOR_X2[0]
    && ADC_GAIN_FACTOR_X2[3] == ADC_GAIN_FACTOR_X2[0] && ADC_GAIN_FACTOR_X2[4] ==
    ADC_GAIN_FACTOR_X2[0] && ADC_GAIN_FACTOR_X2[5] == ADC_GAIN_FACTOR_X2[0])
    else $error("channel gains differ");
  chk_done_one_pulse: assert property (
    MEAS_DONE |=> !MEAS_DONE) else $error("done pulse too long");
  chk_done_after_integ: assert property (
    MEAS_DONE |-> $past(INTEGRATING) || $past(INTEGRATING, 2)) else $error("done without integ");
  cover property (MEAS_DONE);
  cover property ($rose(INTEGRATING));
  cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule

bind sitim_core sitim_props u_sitim_props (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .INTEGRATING(INTEGRATING),
  .MEAS_DONE(MEAS_DONE), .ADC_FULL_SCALE(ADC_FULL_SCALE), .ADC_GAIN_FACTOR_X2(ADC_GAIN_FACTOR_X2)
);

// [verif/sitim_sync_src.sv]
// far-side model: emits a burst of falling edges on the sync pin
module sitim_sync_src (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] falls,
  input wire logic [7:0] half,
  output logic sync_pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_reg = 8'h00;
  logic [7:0] cnt_reg = 8'h00;
  // pin rests high between bursts, as a pulled-up line would
  initial sync_pin = 1'b1;
  initial busy = 1'b0;
  always @(posedge clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      left_reg <= falls;
      cnt_reg <= half;
    end else if (busy && cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end else if (busy) begin
      cnt_reg <= half;
      sync_pin <= !sync_pin;
      if (sync_pin) left_reg <= left_reg - 8'h01;
      if (!sync_pin && left_reg == 8'h00) busy <= 1'b0;
    end
  end
endmodule

// [verif/test_sitim_core.sv]
// testbench: register access, timed, waited and pulse-terminated runs
module test_sitim_core;
  import sitim_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, go = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, adc_full_scale;
  logic [3:0] avs_byteenable = 4'h0;
  logic avs_waitrequest, sync_pin, integrating, meas_done;
  logic [10:0] adc_gain [NUM_ADC];
  logic [7:0] q;
  int err_total = 0, checks_done = 0, n, m, i, k;
  logic [7:0] ri [9] = '{OFS_STEP_LOW, OFS_STEP_HIGH, OFS_GAIN_CONFIG, OFS_LEN_LOW,
    OFS_LEN_MID, OFS_LEN_HIGH, OFS_SYNC_TARGET, OFS_WAIT_PERIOD, OFS_STATUS};
  logic [7:0] rv [9] = '{8'hE7, 8'h03, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wi [5] = '{OFS_SYNC_TARGET, OFS_WAIT_PERIOD, OFS_STEP_COUNT, OFS_STEP_LOW,
    OFS_STEP_HIGH};
  logic [7:0] wv [5] = '{8'hA5, 8'h5A, 8'h03, 8'h04, 8'h00};

  // tick shortened to 2 clocks, wait cycle to 4 ticks
  sitim_core #(.TICK_CYC(2), .WAIT_TICK_COUNT(4)) u_sitim_core (
    .SYS_CLK(sys_clk), .RESETN(resetn), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .SYNC_IN(sync_pin),
    .INTEGRATING(integrating), .MEAS_DONE(meas_done), .ADC_FULL_SCALE(adc_full_scale),
    .ADC_GAIN_FACTOR_X2(adc_gain));
  sitim_sync_src u_sitim_sync_src (.clk(sys_clk), .go(go), .falls(8'h04), .half(8'h09),
    .sync_pin(sync_pin), .busy());

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] be);
    avs_address <= {a, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, 4'hF);
    chk({24'h0, q}, {24'h0, e});
  endtask
  // waits until the integrating flag takes level v, counting cycles
  task automatic wait_int(input logic v, output int c);
    c = 0;
    while (integrating !== v && c < 2000) begin
      @(posedge sys_clk);
      c++;
    end
    if (c >= 2000) chk(32'h0, 32'h1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // all scenarios together need about 500 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    results();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    for (i = 0; i < 9; i++) rd(ri[i], rv[i]);
    // step size stays 4, count 3: never all ones, never both zero
    for (i = 0; i < 5; i++) wr(wi[i], wv[i]);
    for (i = 0; i < 5; i++) rd(wi[i], wv[i]);
    chk(adc_full_scale, 32'd20);
    wr(OFS_LEN_LOW, 8'h55);
    rd(OFS_LEN_LOW, 8'h00);
    wr(8'h10, 8'h77);
    rd(8'h10, 8'h00);
    acc(1'b1, OFS_SYNC_TARGET, 8'h11, 4'h0);
    rd(OFS_SYNC_TARGET, 8'hA5);
    for (i = 0; i < 12; i++) begin
      wr(OFS_GAIN_CONFIG, (i == 11) ? 8'hFF : 8'(i));
      repeat (2) @(posedge sys_clk);
      for (k = 0; k < NUM_ADC; k++) begin
        chk(32'(adc_gain[k]), 32'h1 << ((i == 11) ? 10 : i));
      end
    end
    rd(OFS_GAIN_CONFIG, 8'h1F);
    wr(OFS_WAIT_PERIOD, 8'h01);
    wr(OFS_MODE, 8'h00);
    wr(OFS_ENABLE, 8'h0A);
    wait_int(1'b1, n);
    wait_int(1'b0, n);
    chk(32'(n > 37 && n < 43), 32'h1);
    rd(OFS_STATUS, 8'h10);
    wr(OFS_ENABLE, 8'h00);
    wait_int(1'b0, n);
    wr(OFS_WAIT_PERIOD, 8'h09);
    wr(OFS_STATUS, 8'h10);
    rd(OFS_STATUS, 8'h00);
    wr(OFS_ENABLE, 8'h0A);
    wait_int(1'b1, n);
    wait_int(1'b0, n);
    wait_int(1'b1, m);
    chk(32'(n + m > 77 && n + m < 83), 32'h1);
    rd(OFS_STATUS, 8'h00);
    wr(OFS_ENABLE, 8'h00);
    wait_int(1'b0, n);
    wr(OFS_SYNC_TARGET, 8'h02);
    wr(OFS_MODE, 8'h03);
    wr(OFS_ENABLE, 8'h02);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    n = 0;
    while (meas_done !== 1'b1 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n < 500), 32'h1);
    wr(OFS_ENABLE, 8'h00);
    acc(1'b0, OFS_LEN_LOW, 8'h00, 4'hF);
    m = q;
    chk(32'(q > 8'd28 && q < 8'd32), 32'h1);
    rd(OFS_LEN_MID, 8'h00);
    rd(OFS_LEN_HIGH, 8'h00);
    wr(OFS_LEN_LOW, 8'hFF);
    rd(OFS_LEN_LOW, 8'(m));
    // externally started: nothing runs until the first sync fall
    wr(OFS_MODE, 8'h01);
    wr(OFS_ENABLE, 8'h02);
    repeat (30) @(posedge sys_clk);
    chk({31'h0, integrating}, 32'h0);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    wait_int(1'b1, n);
    chk(32'(n > 9 && n < 20), 32'h1);
    wait_int(1'b0, n);
    chk(32'(n > 37 && n < 43), 32'h1);
    wr(OFS_ENABLE, 8'h00);
    wait_int(1'b0, n);
    // a timed run leaves the measured length alone
    rd(OFS_LEN_LOW, 8'(m));
    results();
  end
endmodule
